// >>> hw/dual_sync.sv
// Two-stage sampler for arbitration inputs, advanced only on enabled cycles.
// Assumes the enable marks local bus clock falling edges.
module dual_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st = st;
    if (en_i) begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
    end
  end

  // Inactive-high bus lines, so reset to all ones
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule // dual_sync

// >>> hw/lbus_pkg.sv
// Shared constants and state codes for the strobe-protocol local bus port.
// Assumes one system clock that oversamples the local bus clock pin.
package lbus_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFFS_W = 12;
  localparam int TC_W = 4;
  localparam int SIZ_W = 2;
  localparam int ARB_W = 2;
  localparam int TAP_CNT_W = 3;
  // One less than the test clock rises with mode-select high that force the test controller to reset
  localparam logic [TAP_CNT_W-1:0] TAP_HOLD_COUNT = 3'h5;
  localparam logic [TAP_CNT_W-1:0] TAP_CNT_ONE = 3'h1;
  localparam logic ACTIVE_N = 1'b0;
  localparam logic IDLE_N = 1'b1;
  localparam logic DRIVE_OE_N = 1'b0;
  localparam logic FLOAT_OE_N = 1'b1;
  localparam int ARB_GRANT_BIT = 0;
  localparam int ARB_BUSY_BIT = 1;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_QUAL = 3'h1,
    S_WAIT = 3'h2,
    S_TERM = 3'h3,
    S_REL = 3'h4
  } slave_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_REQ = 3'h1,
    M_OWN = 3'h2,
    M_ADDR = 3'h3,
    M_DATA = 3'h4,
    M_WAIT = 3'h5,
    M_REL = 3'h6
  } master_state_t;
endpackage

// >>> hw/local_bus_strobe_interface.sv
// Strobe-protocol local bus port: slave decode, master sequencing, arbitration,
// straps and test-port reset hold. Assumes all pins except the arbitration inputs
// synchronous to clock_i, which runs much faster than the local bus clock it samples.

module local_bus_strobe_interface #(
  parameter int ADDR_W = lbus_pkg::ADDR_W,
  parameter int DATA_W = lbus_pkg::DATA_W
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic local_bus_clock_i,
  // Straps and options
  input wire logic pci_reset_n_i,
  input wire logic burst_in_progress_n_i,
  input wire logic bus_master_strap_fifo_ready_i,
  input wire logic sync_arbitration_i,
  output logic alt_master_protocol_o,
  output logic pci_bus_master_enable_o,
  // Test port
  input wire logic test_clock_i,
  input wire logic test_mode_select_i,
  input wire logic test_reset_n_i,
  output logic test_controller_reset_o,
  // Arbitration pins
  output logic bus_request_n_o,
  input wire logic bus_grant_n_i,
  input wire logic bus_busy_grant_ack_n_i,
  output logic bus_busy_grant_ack_n_o,
  output logic bus_busy_grant_ack_oe_n_o,
  // Address phase pins
  input wire logic address_strobe_n_i,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic strobe_oe_n_o,
  input wire logic [ADDR_W-1:0] address_i,
  output logic [ADDR_W-1:0] address_o,
  input wire logic [lbus_pkg::TC_W-1:0] transaction_code_i,
  output logic [lbus_pkg::TC_W-1:0] transaction_code_o,
  input wire logic [lbus_pkg::SIZ_W-1:0] transfer_size_i,
  output logic [lbus_pkg::SIZ_W-1:0] transfer_size_o,
  input wire logic read_write_n_i,
  output logic read_write_n_o,
  input wire logic register_select_n_i,
  input wire logic pci_window_select_n_i,
  input wire logic dma_acknowledge_n_i,
  // Data pins
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  // Termination pins
  input wire logic size_ack_high_n_i,
  output logic size_ack_high_n_o,
  output logic size_ack_low_n_o,
  output logic size_ack_oe_n_o,
  input wire logic bus_error_n_i,
  output logic bus_error_n_o,
  input wire logic halt_retry_n_i,
  output logic halt_retry_n_o,
  output logic error_oe_n_o,
  // Slave side toward internal targets
  output logic reg_req_o,
  output logic pci_req_o,
  output logic local_dma_transfer_o,
  output logic dma_single_address_o,
  output logic [lbus_pkg::OFFS_W-1:0] reg_offset_o,
  output logic [ADDR_W-1:0] slv_addr_o,
  output logic [lbus_pkg::TC_W-1:0] slv_code_o,
  output logic [lbus_pkg::SIZ_W-1:0] slv_size_o,
  output logic slv_read_o,
  output logic [DATA_W-1:0] slv_wdata_o,
  input wire logic slv_ack_i,
  input wire logic slv_err_i,
  input wire logic slv_retry_i,
  input wire logic [DATA_W-1:0] slv_rdata_i,
  // Master side toward internal requester
  input wire logic mst_req_i,
  input wire logic [ADDR_W-1:0] mst_addr_i,
  input wire logic [lbus_pkg::TC_W-1:0] mst_code_i,
  input wire logic [lbus_pkg::SIZ_W-1:0] mst_size_i,
  input wire logic mst_read_i,
  input wire logic [DATA_W-1:0] mst_wdata_i,
  output logic mst_busy_o,
  output logic mst_done_o,
  output logic mst_err_o,
  output logic mst_retry_o,
  output logic [DATA_W-1:0] mst_rdata_o
);
  typedef struct packed {
    logic lclk;
    logic tck;
    logic strap_done;
    logic [lbus_pkg::TAP_CNT_W-1:0] tap_cnt;
    logic tap_rst;
    logic alt_proto;
    logic pci_bm;
    lbus_pkg::slave_state_t sst;
    lbus_pkg::master_state_t mst;
    logic rsp_v;
    logic rsp_err;
    logic rsp_retry;
    logic req_n;
    logic bb_n;
    logic bb_oe_n;
    logic as_n;
    logic ds_n;
    logic strb_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [lbus_pkg::TC_W-1:0] tc;
    logic [lbus_pkg::SIZ_W-1:0] siz;
    logic rw_n;
    logic [DATA_W-1:0] dout;
    logic d_oe_n;
    logic ack_n;
    logic ack_oe_n;
    logic berr_n;
    logic halt_n;
    logic err_oe_n;
    logic reg_req;
    logic pci_req;
    logic sel_reg;
    logic dma;
    logic single;
    logic [ADDR_W-1:0] s_addr;
    logic [lbus_pkg::TC_W-1:0] s_tc;
    logic [lbus_pkg::SIZ_W-1:0] s_siz;
    logic s_read;
    logic [DATA_W-1:0] s_wdata;
    logic m_read;
    logic done;
    logic m_err;
    logic m_retry;
    logic [DATA_W-1:0] m_rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic rise;
  logic fall;
  logic [lbus_pkg::ARB_W-1:0] arb_sync;
  logic grant_n;
  logic busy_n;
  logic selected;

  assign rise = local_bus_clock_i && !st.lclk;
  assign fall = !local_bus_clock_i && st.lclk;
  assign selected = !register_select_n_i || !pci_window_select_n_i || !dma_acknowledge_n_i;

  dual_sync #(.WIDTH(lbus_pkg::ARB_W)) u_arb_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .en_i(ce_i && fall),
    .d_i({bus_busy_grant_ack_n_i, bus_grant_n_i}),
    .q_o(arb_sync)
  );

  // Raw pins are taken as already synchronous when so configured
  assign grant_n = sync_arbitration_i ? bus_grant_n_i : arb_sync[lbus_pkg::ARB_GRANT_BIT];
  assign busy_n = sync_arbitration_i ? bus_busy_grant_ack_n_i : arb_sync[lbus_pkg::ARB_BUSY_BIT];

  always_comb begin
    next_st = st;
    next_st.lclk = local_bus_clock_i;
    next_st.tck = test_clock_i;
    next_st.reg_req = 1'b0;
    next_st.pci_req = 1'b0;
    next_st.done = 1'b0;
    // Straps: protocol caught once after release, master enable while PCI reset holds
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.alt_proto = burst_in_progress_n_i;
    end
    if (!pci_reset_n_i) begin
      next_st.pci_bm = bus_master_strap_fifo_ready_i;
    end
    // Undriven test reset still resets through mode-select held high
    if (!test_reset_n_i) begin
      next_st.tap_rst = 1'b1;
      next_st.tap_cnt = '0;
    end else if (test_clock_i && !st.tck) begin
      if (!test_mode_select_i) begin
        next_st.tap_cnt = '0;
        next_st.tap_rst = 1'b0;
      end else if (st.tap_cnt == lbus_pkg::TAP_HOLD_COUNT) begin
        next_st.tap_rst = 1'b1;
      end else begin
        next_st.tap_cnt = st.tap_cnt + lbus_pkg::TAP_CNT_ONE;
      end
    end
    // Slave
    if (slv_ack_i && st.sst == lbus_pkg::S_WAIT) begin
      next_st.rsp_v = 1'b1;
      next_st.rsp_err = slv_err_i || slv_retry_i;
      next_st.rsp_retry = slv_retry_i;
      next_st.dout = slv_rdata_i;
      next_st.d_oe_n = st.s_read ? lbus_pkg::DRIVE_OE_N : lbus_pkg::FLOAT_OE_N;
    end
    case (st.sst)
      lbus_pkg::S_IDLE: begin
        if (fall && !address_strobe_n_i && selected && st.mst == lbus_pkg::M_IDLE) begin
          next_st.s_addr = address_i;
          next_st.sel_reg = !register_select_n_i;
          next_st.dma = !dma_acknowledge_n_i;
          next_st.single = pci_window_select_n_i;
          next_st.sst = lbus_pkg::S_QUAL;
        end
      end
      lbus_pkg::S_QUAL: begin
        // Write data is valid at the rise after the strobe, no data strobe used
        if (rise) begin
          next_st.s_wdata = data_i;
        end
        // Qualifiers re-taken one bus clock later, so late setup is tolerated
        if (fall) begin
          if (address_strobe_n_i) begin
            next_st.sst = lbus_pkg::S_IDLE;
          end else begin
            next_st.s_addr = address_i;
            next_st.s_tc = transaction_code_i;
            next_st.s_siz = transfer_size_i;
            next_st.s_read = read_write_n_i;
            next_st.reg_req = st.sel_reg && !st.dma;
            next_st.pci_req = !st.sel_reg || st.dma;
            next_st.rsp_v = 1'b0;
            next_st.sst = lbus_pkg::S_WAIT;
          end
        end
      end
      lbus_pkg::S_WAIT: begin
        if (fall && st.rsp_v) begin
          if (st.rsp_err) begin
            next_st.berr_n = lbus_pkg::ACTIVE_N;
            next_st.halt_n = st.rsp_retry ? lbus_pkg::ACTIVE_N : lbus_pkg::IDLE_N;
            next_st.err_oe_n = lbus_pkg::DRIVE_OE_N;
          end else begin
            next_st.ack_n = lbus_pkg::ACTIVE_N;
            next_st.ack_oe_n = lbus_pkg::DRIVE_OE_N;
          end
          next_st.sst = lbus_pkg::S_TERM;
        end
      end
      lbus_pkg::S_TERM: begin
        if (fall && address_strobe_n_i) begin
          next_st.ack_n = lbus_pkg::IDLE_N;
          next_st.berr_n = lbus_pkg::IDLE_N;
          next_st.halt_n = lbus_pkg::IDLE_N;
          next_st.d_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.sst = lbus_pkg::S_REL;
        end
      end
      lbus_pkg::S_REL: begin
        if (fall) begin
          next_st.ack_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.err_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.sst = lbus_pkg::S_IDLE;
        end
      end
      default: next_st.sst = lbus_pkg::S_IDLE;
    endcase
    // Master
    case (st.mst)
      lbus_pkg::M_IDLE: begin
        if (mst_req_i && st.sst == lbus_pkg::S_IDLE) begin
          next_st.addr = mst_addr_i;
          next_st.tc = mst_code_i;
          next_st.siz = mst_size_i;
          next_st.m_read = mst_read_i;
          next_st.dout = mst_wdata_i;
          next_st.mst = lbus_pkg::M_REQ;
        end
      end
      lbus_pkg::M_REQ: begin
        if (fall) begin
          if (!st.req_n && !grant_n && busy_n) begin
            next_st.req_n = lbus_pkg::IDLE_N;
            next_st.bb_n = lbus_pkg::ACTIVE_N;
            next_st.bb_oe_n = lbus_pkg::DRIVE_OE_N;
            next_st.mst = lbus_pkg::M_OWN;
          end else begin
            next_st.req_n = lbus_pkg::ACTIVE_N;
          end
        end
      end
      lbus_pkg::M_OWN: begin
        if (rise) begin
          next_st.strb_oe_n = lbus_pkg::DRIVE_OE_N;
          next_st.rw_n = st.m_read;
          next_st.d_oe_n = st.m_read ? lbus_pkg::FLOAT_OE_N : lbus_pkg::DRIVE_OE_N;
          next_st.mst = lbus_pkg::M_ADDR;
        end
      end
      lbus_pkg::M_ADDR: begin
        if (fall) begin
          next_st.as_n = lbus_pkg::ACTIVE_N;
          next_st.ds_n = st.m_read ? lbus_pkg::ACTIVE_N : lbus_pkg::IDLE_N;
          next_st.mst = lbus_pkg::M_DATA;
        end
      end
      lbus_pkg::M_DATA: begin
        // Write strobe follows the address strobe by one bus clock
        if (fall) begin
          next_st.ds_n = lbus_pkg::ACTIVE_N;
          next_st.mst = lbus_pkg::M_WAIT;
        end
      end
      lbus_pkg::M_WAIT: begin
        if (fall && (!size_ack_high_n_i || !bus_error_n_i)) begin
          next_st.done = 1'b1;
          next_st.m_err = !bus_error_n_i && halt_retry_n_i;
          next_st.m_retry = !bus_error_n_i && !halt_retry_n_i;
          next_st.m_rdata = data_i;
          next_st.as_n = lbus_pkg::IDLE_N;
          next_st.ds_n = lbus_pkg::IDLE_N;
          next_st.bb_n = lbus_pkg::IDLE_N;
          next_st.d_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.mst = lbus_pkg::M_REL;
        end
      end
      lbus_pkg::M_REL: begin
        if (fall) begin
          next_st.strb_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.bb_oe_n = lbus_pkg::FLOAT_OE_N;
          next_st.mst = lbus_pkg::M_IDLE;
        end
      end
      default: next_st.mst = lbus_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.tap_rst <= 1'b1;
      st.req_n <= lbus_pkg::IDLE_N;
      st.bb_n <= lbus_pkg::IDLE_N;
      st.bb_oe_n <= lbus_pkg::FLOAT_OE_N;
      st.as_n <= lbus_pkg::IDLE_N;
      st.ds_n <= lbus_pkg::IDLE_N;
      st.strb_oe_n <= lbus_pkg::FLOAT_OE_N;
      st.d_oe_n <= lbus_pkg::FLOAT_OE_N;
      st.ack_n <= lbus_pkg::IDLE_N;
      st.ack_oe_n <= lbus_pkg::FLOAT_OE_N;
      st.berr_n <= lbus_pkg::IDLE_N;
      st.halt_n <= lbus_pkg::IDLE_N;
      st.err_oe_n <= lbus_pkg::FLOAT_OE_N;
      st.rw_n <= lbus_pkg::IDLE_N;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign alt_master_protocol_o = st.alt_proto;
  assign pci_bus_master_enable_o = st.pci_bm;
  assign test_controller_reset_o = st.tap_rst;
  assign bus_request_n_o = st.req_n;
  assign bus_busy_grant_ack_n_o = st.bb_n;
  assign bus_busy_grant_ack_oe_n_o = st.bb_oe_n;
  assign address_strobe_n_o = st.as_n;
  assign data_strobe_n_o = st.ds_n;
  assign strobe_oe_n_o = st.strb_oe_n;
  assign address_o = st.addr;
  assign transaction_code_o = st.tc;
  assign transfer_size_o = st.siz;
  assign read_write_n_o = st.rw_n;
  assign data_o = st.dout;
  assign data_oe_n_o = st.d_oe_n;
  assign size_ack_high_n_o = st.ack_n;
  assign size_ack_low_n_o = st.ack_n;
  assign size_ack_oe_n_o = st.ack_oe_n;
  assign bus_error_n_o = st.berr_n;
  assign halt_retry_n_o = st.halt_n;
  assign error_oe_n_o = st.err_oe_n;
  assign reg_req_o = st.reg_req;
  assign pci_req_o = st.pci_req;
  assign local_dma_transfer_o = st.dma;
  assign dma_single_address_o = st.single;
  assign reg_offset_o = st.s_addr[lbus_pkg::OFFS_W-1:0];
  assign slv_addr_o = st.s_addr;
  assign slv_code_o = st.s_tc;
  assign slv_size_o = st.s_siz;
  assign slv_read_o = st.s_read;
  assign slv_wdata_o = st.s_wdata;
  assign mst_busy_o = (st.mst != lbus_pkg::M_IDLE);
  assign mst_done_o = st.done;
  assign mst_err_o = st.m_err;
  assign mst_retry_o = st.m_retry;
  assign mst_rdata_o = st.m_rdata;

  AST_SLV_ADDR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && fall && st.sst == lbus_pkg::S_IDLE && next_st.sst == lbus_pkg::S_QUAL)
    |=> st.s_addr == $past(address_i))
    else $error("slave address not captured with strobe");
  AST_SLV_ACCEPT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st.sst == lbus_pkg::S_QUAL && $past(st.sst) == lbus_pkg::S_IDLE)
    |-> $past(fall && !address_strobe_n_i && selected))
    else $error("slave cycle accepted without select");
  AST_REG_OFFSET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_req_o |-> reg_offset_o == $past(address_i[lbus_pkg::OFFS_W-1:0]))
    else $error("register offset not from low address bits");
  AST_AS_TIMING: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(address_strobe_n_o) |-> $past(fall) && $past(!strobe_oe_n_o))
    else $error("address strobe asserted off a falling edge");
  AST_BB_RELEASE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(bus_busy_grant_ack_oe_n_o) |-> $past(bus_busy_grant_ack_n_o) && $past(fall))
    else $error("busy line floated while low");
  AST_BERR_RELEASE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(error_oe_n_o) |-> $past(bus_error_n_o) && $past(halt_retry_n_o))
    else $error("bus error floated while asserted");
  AST_REQ_EDGE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $changed(bus_request_n_o) |-> $past(fall))
    else $error("bus request changed off a falling edge");
  AST_SIZE_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !size_ack_high_n_o |-> !size_ack_low_n_o && !size_ack_oe_n_o && error_oe_n_o)
    else $error("termination not full width");
  AST_RETRY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (mst_done_o && mst_retry_o) |-> $past(!bus_error_n_i && !halt_retry_n_i && fall))
    else $error("retry reported without error and halt");
  AST_DS_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ($fell(data_strobe_n_o) && !st.m_read) |-> !address_strobe_n_o && $past(!address_strobe_n_o))
    else $error("write data strobe before address strobe");
endmodule // local_bus_strobe_interface

// >>> verification/local_bus_far_model.sv
// Far side: bus clock, arbiter and a slave for port master cycles.
// Assumes the port's system clock and a pulled-up bus.
module local_bus_far_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Answer kind: 0 ack, 1 error, 2 retry
  input wire logic [1:0] mode_i,
  input wire logic [31:0] rdata_i,
  // Port pins watched
  input wire logic bus_request_n_i,
  input wire logic strobe_oe_n_i,
  input wire logic address_strobe_n_i,
  input wire logic data_strobe_n_i,
  input wire logic read_write_n_i,
  input wire logic [31:0] address_i,
  input wire logic [31:0] data_i,
  // Pins driven
  output logic local_bus_clock_o,
  output logic bus_grant_n_o,
  output logic size_ack_n_o,
  output logic bus_error_n_o,
  output logic halt_retry_n_o,
  output logic [31:0] data_o,
  output logic [31:0] seen_addr_o,
  output logic [31:0] seen_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div;
  logic [3:0] pat;
  logic waited;
  logic rise;
  logic owned;
  assign rise = (div == 2'h3) && !local_bus_clock_o;
  assign owned = !strobe_oe_n_i && !address_strobe_n_i;
  // Released data lines move every cycle so a stale word cannot pass
  assign data_o = size_ack_n_o ? {8{pat}} : rdata_i;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 2'h0;
      pat <= 4'h0;
      waited <= 1'b0;
      local_bus_clock_o <= 1'b1;
      bus_grant_n_o <= 1'b1;
      size_ack_n_o <= 1'b1;
      bus_error_n_o <= 1'b1;
      halt_retry_n_o <= 1'b1;
      seen_addr_o <= 32'h0;
      seen_data_o <= 32'h0;
    end else begin
      div <= div + 2'h1;
      pat <= pat + 4'h1;
      if (div == 2'h3) local_bus_clock_o <= !local_bus_clock_o;
      if (div == 2'h3 && local_bus_clock_o && owned) begin
        seen_addr_o <= address_i;
        if (!data_strobe_n_i && !read_write_n_i) seen_data_o <= data_i;
      end
      if (rise) begin
        // Grant simply mirrors request; one bus clock of wait before answering
        bus_grant_n_o <= bus_request_n_i;
        waited <= owned;
        if (owned && waited) begin
          size_ack_n_o <= mode_i != 2'h0;
          bus_error_n_o <= mode_i == 2'h0;
          halt_retry_n_o <= mode_i != 2'h2;
        end else if (!owned) begin
          size_ack_n_o <= 1'b1;
          bus_error_n_o <= 1'b1;
          halt_retry_n_o <= 1'b1;
        end
      end
    end
  end
endmodule // local_bus_far_model

// >>> verification/local_bus_strobe_interface_test.sv
// Bench: host cycles, port master cycles, straps and test reset.
// Assumes the far model makes the bus clock and pulls lines high.
module local_bus_strobe_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  int n_fail = 0;
  int n_checks = 0;
  logic clock_i, rst_n_i, ce_i, pci_reset_n_i, burst_in_progress_n_i, bus_master_strap_fifo_ready_i;
  logic sync_arbitration_i, test_clock_i, test_mode_select_i, test_reset_n_i, read_write_n_i, h_as;
  logic register_select_n_i, pci_window_select_n_i, dma_acknowledge_n_i, slv_ack_i, slv_err_i, slv_retry_i;
  logic mst_req_i, mst_read_i, p_ack, p_berr, p_halt, local_bus_clock_i, bus_grant_n_i;
  logic alt_master_protocol_o, pci_bus_master_enable_o, test_controller_reset_o, bus_request_n_o;
  logic bus_busy_grant_ack_n_o, bus_busy_grant_ack_oe_n_o, address_strobe_n_o, data_strobe_n_o, strobe_oe_n_o;
  logic read_write_n_o, data_oe_n_o, size_ack_high_n_o, size_ack_low_n_o, size_ack_oe_n_o, bus_error_n_o;
  logic halt_retry_n_o, error_oe_n_o, reg_req_o, pci_req_o, local_dma_transfer_o, dma_single_address_o;
  logic slv_read_o, mst_busy_o, mst_done_o, mst_err_o, mst_retry_o;
  logic [1:0] p_mode, transfer_size_i, transfer_size_o, slv_size_o, mst_size_i;
  logic [3:0] transaction_code_i, transaction_code_o, slv_code_o, mst_code_i;
  logic [11:0] reg_offset_o;
  logic [31:0] h_addr, h_data, p_data, p_rdata, seen_addr, seen_data, address_o, data_o, slv_addr_o;
  logic [31:0] slv_wdata_o, slv_rdata_i, mst_addr_i, mst_wdata_i, mst_rdata_o;
  wire logic bus_busy_grant_ack_n_i, address_strobe_n_i, size_ack_high_n_i, bus_error_n_i, halt_retry_n_i;
  wire logic [31:0] address_i, data_i;
  // Shared pins resolve to whoever drives them; the port's enables decide
  assign bus_busy_grant_ack_n_i = bus_busy_grant_ack_oe_n_o | bus_busy_grant_ack_n_o;
  assign address_strobe_n_i = strobe_oe_n_o ? h_as : address_strobe_n_o;
  assign address_i = strobe_oe_n_o ? h_addr : address_o;
  assign data_i = strobe_oe_n_o ? h_data : p_data;
  assign size_ack_high_n_i = size_ack_oe_n_o ? p_ack : size_ack_high_n_o;
  assign bus_error_n_i = error_oe_n_o ? p_berr : bus_error_n_o;
  assign halt_retry_n_i = error_oe_n_o ? p_halt : halt_retry_n_o;
  local_bus_strobe_interface u_local_bus_strobe_interface (.*);
  local_bus_far_model u_local_bus_far_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(p_mode),
    .rdata_i(p_rdata), .bus_request_n_i(bus_request_n_o), .strobe_oe_n_i(strobe_oe_n_o),
    .address_strobe_n_i(address_strobe_n_o), .data_strobe_n_i(data_strobe_n_o), .read_write_n_i(read_write_n_o),
    .address_i(address_o), .data_i(data_o), .local_bus_clock_o(local_bus_clock_i), .bus_grant_n_o(bus_grant_n_i),
    .size_ack_n_o(p_ack), .bus_error_n_o(p_berr), .halt_retry_n_o(p_halt), .data_o(p_data),
    .seen_addr_o(seen_addr), .seen_data_o(seen_data));
  always #2 clock_i = ~clock_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic strap_test();
    rst_n_i = 1'b0;
    pci_reset_n_i = 1'b0;
    burst_in_progress_n_i = 1'b0;
    bus_master_strap_fifo_ready_i = 1'b0;
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(alt_master_protocol_o, 1'b0);
    check(pci_bus_master_enable_o, 1'b0);
    pci_reset_n_i = 1'b1;
    bus_master_strap_fifo_ready_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(pci_bus_master_enable_o, 1'b0);
    $display("straps done");
  endtask
  task automatic tck(input int n);
    repeat (n) begin
      repeat (3) @(negedge clock_i);
      test_clock_i = 1'b1;
      repeat (3) @(negedge clock_i);
      test_clock_i = 1'b0;
    end
  endtask
  task automatic tap_test();
    test_mode_select_i = 1'b0;
    tck(1);
    check(test_controller_reset_o, 1'b0);
    test_mode_select_i = 1'b1;
    tck(6);
    check(test_controller_reset_o, 1'b1);
    test_mode_select_i = 1'b0;
    tck(1);
    test_reset_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check(test_controller_reset_o, 1'b1);
    test_reset_n_i = 1'b1;
    $display("test port done");
  endtask
  task automatic slave_cycle(input logic rs, ws, dma, rd, late, input logic [1:0] kind, input logic [31:0] a);
    int i;
    @(posedge local_bus_clock_i);
    @(negedge clock_i);
    h_addr = late ? ~a : a;
    h_data = ~a;
    read_write_n_i = rd;
    register_select_n_i = !rs;
    pci_window_select_n_i = !ws;
    dma_acknowledge_n_i = !dma;
    h_as = 1'b0;
    if (late) begin
      @(negedge local_bus_clock_i);
      repeat (2) @(negedge clock_i);
      h_addr = a;
    end
    for (i = 0; i < 60 && reg_req_o !== 1'b1 && pci_req_o !== 1'b1; i++) @(negedge clock_i);
    check(reg_req_o, rs && !dma);
    check(pci_req_o, ws || dma);
    if (rs || ws || dma) begin
      check(slv_addr_o, a);
      check(reg_offset_o, a[11:0]);
      check(slv_read_o, rd);
      check({slv_code_o, slv_size_o}, 6'h3C);
      check(slv_wdata_o, ~a);
      check(local_dma_transfer_o, dma);
      if (dma) check(dma_single_address_o, !ws);
      slv_ack_i = 1'b1;
      slv_err_i = kind != 2'h0;
      slv_retry_i = kind == 2'h2;
      slv_rdata_i = a ^ 32'h5A5A_5A5A;
      @(negedge clock_i);
      slv_ack_i = 1'b0;
      for (i = 0; i < 60 && size_ack_low_n_o !== 1'b0 && bus_error_n_o !== 1'b0; i++) @(negedge clock_i);
      check(size_ack_high_n_o, kind != 2'h0);
      check(size_ack_low_n_o, kind != 2'h0);
      check(bus_error_n_o, kind == 2'h0);
      check(halt_retry_n_o, kind != 2'h2);
      if (rd && kind == 2'h0) check(data_o, a ^ 32'h5A5A_5A5A);
    end
    @(posedge local_bus_clock_i);
    @(negedge clock_i);
    h_as = 1'b1;
    {register_select_n_i, pci_window_select_n_i, dma_acknowledge_n_i} = 3'h7;
    for (i = 0; i < 60 && (size_ack_oe_n_o !== 1'b1 || error_oe_n_o !== 1'b1); i++) @(negedge clock_i);
    check(size_ack_high_n_o, 1'b1);
    check(bus_error_n_o, 1'b1);
    repeat (24) @(negedge clock_i);
    $display("slave cycle %h done", a);
  endtask
  task automatic master_cycle(input logic rd, input logic [1:0] kind, input logic [31:0] a);
    int i;
    p_mode = kind;
    mst_read_i = rd;
    mst_addr_i = a;
    mst_wdata_i = ~a;
    mst_req_i = 1'b1;
    for (i = 0; i < 20 && mst_busy_o !== 1'b1; i++) @(negedge clock_i);
    mst_req_i = 1'b0;
    for (i = 0; i < 400 && mst_done_o !== 1'b1; i++) @(negedge clock_i);
    check(mst_done_o, 1'b1);
    check(mst_err_o, kind == 2'h1);
    check({transaction_code_o, transfer_size_o}, 6'h28);
    check(mst_retry_o, kind == 2'h2);
    check(seen_addr, a);
    if (rd && kind == 2'h0) check(mst_rdata_o, p_rdata);
    if (!rd) check(seen_data, ~a);
    for (i = 0; i < 60 && bus_busy_grant_ack_oe_n_o !== 1'b1; i++) @(negedge clock_i);
    check(bus_busy_grant_ack_n_o, 1'b1);
    check({strobe_oe_n_o, address_strobe_n_o, data_strobe_n_o}, 3'h7);
    check(bus_request_n_o, 1'b1);
    repeat (16) @(negedge clock_i);
    $display("master cycle %h done", a);
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    {clock_i, rst_n_i, pci_reset_n_i, test_clock_i, sync_arbitration_i, slv_ack_i} = 6'h0;
    {ce_i, burst_in_progress_n_i, bus_master_strap_fifo_ready_i, test_mode_select_i, test_reset_n_i} = 5'h1F;
    {h_as, read_write_n_i, register_select_n_i, pci_window_select_n_i, dma_acknowledge_n_i} = 5'h1F;
    {slv_err_i, slv_retry_i, mst_req_i, mst_read_i, p_mode} = 6'h0;
    {h_addr, h_data, slv_rdata_i, mst_addr_i, mst_wdata_i} = '0;
    transaction_code_i = 4'hF;
    transfer_size_i = 2'h0;
    mst_code_i = 4'hA;
    mst_size_i = 2'h0;
    p_rdata = 32'hC3A5_0F96;
    repeat (12) @(negedge clock_i);
    check({bus_request_n_o, strobe_oe_n_o, error_oe_n_o, test_controller_reset_o}, 4'hF);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(alt_master_protocol_o, 1'b1);
    check(pci_bus_master_enable_o, 1'b1);
    strap_test();
    tap_test();
    slave_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 32'hABCD_E123);
    slave_cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 32'h1234_5FFC);
    slave_cycle(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 32'h0000_0010);
    slave_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 32'h8000_0004);
    slave_cycle(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 32'h8000_0008);
    slave_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 32'h0000_0FFF);
    slave_cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h2, 32'hFFFF_F000);
    master_cycle(1'b0, 2'h0, 32'h4000_0100);
    master_cycle(1'b1, 2'h0, 32'h4000_0204);
    master_cycle(1'b0, 2'h1, 32'h4000_0308);
    master_cycle(1'b1, 2'h2, 32'h4000_040C);
    sync_arbitration_i = 1'b1;
    master_cycle(1'b1, 2'h0, 32'h7FFF_FFFC);
    test_done();
  end
endmodule // local_bus_strobe_interface_test
